// [tsr_pkg.sv]
package tsr_pkg;

    // ------------------------------------------------------------
    // Status word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int BIT_WAKE = 0;
    localparam int BIT_MODE = 1;
    localparam int BIT_GUARD = 2;
    localparam int BIT_RX = 3;
    localparam int BIT_PWR = 4;
    localparam int BIT_BUS = 5;
    localparam int BIT_OTEMP = 6;
    localparam int BIT_TXTO = 7;
    localparam int BIT_VCCUV = 8;
    localparam int BIT_VIOUV = 9;
    localparam int BIT_SPIERR = 10;
    localparam int BIT_WARN = 11;
    localparam int BIT_SUM = 12;
    localparam int BIT_RSV_HI = 13;
    localparam int BIT_RSV_LO = 14;
    localparam int BIT_PAR = 15;

    // Bits held by a latch cell, and bits that feed the summary flag
    localparam logic [WORD_W-1:0] LATCH_MASK = 16'h0ff5;
    localparam logic [WORD_W-1:0] ERR_MASK = 16'h07e4;
    localparam logic RSV_HI_VAL = 1'h1;
    localparam logic RSV_LO_VAL = 1'h0;

    // ------------------------------------------------------------
    // Serial frame and timing
    // ------------------------------------------------------------
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
    localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
    localparam int CLK_PERIOD_NS = 100;
    localparam int READOUT_TIME_NS = 2000000;
    localparam int READOUT_CYCLES = READOUT_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 16;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_SHIFT,
        SPI_FLOAT
    } spi_state_t;

endpackage

// [sync_stage.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Two-flop synchroniser for pins from outside the clock domain
// ------------------------------------------------------------
module sync_stage #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and control
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            meta <= INIT;
            sync_o <= INIT;
        end else if (ce_i) begin
            meta <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// [flag_cell.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// One latched event flag, held high internally while set
// ------------------------------------------------------------
module flag_cell (
    // Clock and control
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Event and clear
    input wire logic cond_i,
    input wire logic clear_i,
    output logic latched_o
);

    // Set beats clear, so a persisting condition keeps the flag
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            latched_o <= 1'h0;
        end else if (ce_i) begin
            if (cond_i) begin
                latched_o <= 1'h1;
            end else if (clear_i) begin
                latched_o <= 1'h0;
            end
        end
    end

    property p_persist;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && cond_i && clear_i) |=> latched_o;
    endproperty
    a_persist: assert property (p_persist)
        else $error("flag cleared while its condition persists");

    property p_hold;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && latched_o && !clear_i) |=> latched_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("latched flag dropped without a clear");

endmodule

// [transceiver_status_register.sv]
`timescale 1ns/1ps

module transceiver_status_register #(
    parameter int READOUT_CYCLES = tsr_pkg::READOUT_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Serial port pins
    input wire logic serial_select_n_i,
    input wire logic sclk_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    // Control pins
    input wire logic standby_control_n_i,
    input wire logic guardian_enable_i,
    output logic error_out_n_o,
    // Mode sequencer, same clock
    input wire logic active_normal_mode_i,
    input wire logic mode_change_i,
    // Event detectors, same clock, active high
    input wire logic wake_event_i,
    input wire logic power_on_event_i,
    input wire logic bus_error_i,
    input wire logic overtemp_i,
    input wire logic tx_timeout_i,
    input wire logic vcc_uv_i,
    input wire logic vio_uv_i,
    input wire logic temp_warn_i,
    input wire logic rx_activity_flag_i
);

    localparam logic [tsr_pkg::TIMER_W-1:0] TIMER_LAST =
        tsr_pkg::TIMER_W'(READOUT_CYCLES - 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic cs_s;
    logic sclk_s;
    logic stby_s;
    logic guard_s;

    // Idle levels: select high, clock low, standby and guardian high
    sync_stage #(.W(4), .INIT(4'hb)) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .async_i({serial_select_n_i, sclk_i, standby_control_n_i,
                  guardian_enable_i}),
        .sync_o({cs_s, sclk_s, stby_s, guard_s})
    );

    // Delayed copies give edges without touching the first stage
    logic cs_q;
    logic sclk_q;
    logic vio_q;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cs_q <= 1'h1;
            sclk_q <= 1'h0;
            vio_q <= 1'h0;
        end else if (ce_i) begin
            cs_q <= cs_s;
            sclk_q <= sclk_s;
            vio_q <= vio_uv_i;
        end
    end

    logic cs_fall;
    logic sclk_rise;
    logic vio_recover;

    assign cs_fall = cs_q & ~cs_s;
    assign sclk_rise = sclk_s & ~sclk_q;
    assign vio_recover = vio_q & ~vio_uv_i;

    // ------------------------------------------------------------
    // Event conditions and latched flags
    // ------------------------------------------------------------
    logic good_read;
    logic spi_err_evt;
    logic clear_evt;
    logic summary;
    logic [tsr_pkg::WORD_W-1:0] cond;
    logic [tsr_pkg::WORD_W-1:0] clr;
    logic [tsr_pkg::WORD_W-1:0] latched;

    // Clear on host mode change or a clean read-out
    assign clear_evt = mode_change_i | good_read;

    // Wake-ups only count while in standby
    always_comb begin
        cond = '0;
        cond[tsr_pkg::BIT_WAKE] = wake_event_i & ~active_normal_mode_i;
        cond[tsr_pkg::BIT_GUARD] = active_normal_mode_i & ~guard_s;
        cond[tsr_pkg::BIT_PWR] = power_on_event_i;
        cond[tsr_pkg::BIT_BUS] = bus_error_i;
        cond[tsr_pkg::BIT_OTEMP] = overtemp_i;
        cond[tsr_pkg::BIT_TXTO] = tx_timeout_i;
        cond[tsr_pkg::BIT_VCCUV] = vcc_uv_i;
        cond[tsr_pkg::BIT_VIOUV] = vio_uv_i;
        cond[tsr_pkg::BIT_SPIERR] = spi_err_evt;
        cond[tsr_pkg::BIT_WARN] = temp_warn_i;
    end

    // The reference flag drops on recovery, leaving the summary set
    always_comb begin
        clr = {tsr_pkg::WORD_W{clear_evt}};
        clr[tsr_pkg::BIT_VIOUV] = clear_evt | vio_recover;
    end

    genvar gi;
    generate
        for (gi = 0; gi < tsr_pkg::WORD_W; gi++) begin : g_flag
            if (tsr_pkg::LATCH_MASK[gi]) begin : g_cell
                flag_cell u_cell (
                    .clk_i(clk_i),
                    .reset_i(reset_i),
                    .ce_i(ce_i),
                    .cond_i(cond[gi]),
                    .clear_i(clr[gi]),
                    .latched_o(latched[gi])
                );
            end else begin : g_none
                assign latched[gi] = 1'h0;
            end
        end
    endgenerate

    // Summary flag, set by any contributing error, set beats clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            summary <= 1'h0;
        end else if (ce_i) begin
            if (|(cond & tsr_pkg::ERR_MASK)) begin
                summary <= 1'h1;
            end else if (clear_evt) begin
                summary <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Status word assembly
    // ------------------------------------------------------------
    logic [tsr_pkg::WORD_W-1:0] status_word;

    // Internal flags are high-true; in the word they are active low, the mode bit is not inverted
    always_comb begin
        status_word = ~latched;
        status_word[tsr_pkg::BIT_MODE] = active_normal_mode_i;
        status_word[tsr_pkg::BIT_RX] = ~rx_activity_flag_i;
        status_word[tsr_pkg::BIT_SUM] = ~summary;
        status_word[tsr_pkg::BIT_RSV_HI] = tsr_pkg::RSV_HI_VAL;
        status_word[tsr_pkg::BIT_RSV_LO] = tsr_pkg::RSV_LO_VAL;
        status_word[tsr_pkg::BIT_PAR] =
            ~^status_word[tsr_pkg::BIT_PAR-1:0];
    end

    // ------------------------------------------------------------
    // Error pin
    // ------------------------------------------------------------
    // Follows the summary every cycle unless the standby pin is low, so a good read refreshes it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            error_out_n_o <= 1'h1;
        end else if (ce_i) begin
            error_out_n_o <= ~(summary & stby_s);
        end
    end

    // ------------------------------------------------------------
    // Serial read-out engine
    // ------------------------------------------------------------
    tsr_pkg::spi_state_t state;
    logic [tsr_pkg::WORD_W-1:0] shreg;
    logic [tsr_pkg::CNT_W-1:0] bit_cnt;
    logic [tsr_pkg::TIMER_W-1:0] timer;
    logic frame_err;

    // Clock edges count only between select edges; the word is
    // frozen at the select fall so one frame reads a stable value
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state <= tsr_pkg::SPI_IDLE;
            shreg <= '0;
            bit_cnt <= '0;
            timer <= '0;
            frame_err <= 1'h0;
            good_read <= 1'h0;
            spi_err_evt <= 1'h0;
            serial_out_o <= 1'h0;
            serial_out_oe_n_o <= 1'h1;
        end else if (ce_i) begin
            good_read <= 1'h0;
            spi_err_evt <= 1'h0;
            case (state)
                tsr_pkg::SPI_IDLE: begin
                    serial_out_oe_n_o <= 1'h1;
                    if (cs_fall) begin
                        state <= tsr_pkg::SPI_SHIFT;
                        shreg <= status_word;
                        serial_out_o <= 1'h0;
                        serial_out_oe_n_o <= 1'h0;
                        bit_cnt <= '0;
                        timer <= '0;
                        frame_err <= sclk_s;
                    end
                end
                tsr_pkg::SPI_SHIFT: begin
                    if (cs_s) begin
                        state <= tsr_pkg::SPI_IDLE;
                        serial_out_oe_n_o <= 1'h1;
                        if (bit_cnt == tsr_pkg::FRAME_BITS && !frame_err) begin
                            good_read <= 1'h1;
                        end else begin
                            spi_err_evt <= 1'h1;
                        end
                    end else if (timer == TIMER_LAST) begin
                        state <= tsr_pkg::SPI_FLOAT;
                        serial_out_oe_n_o <= 1'h1;
                        spi_err_evt <= 1'h1;
                    end else begin
                        timer <= timer + 1'h1;
                        if (sclk_rise) begin
                            serial_out_o <= shreg[tsr_pkg::WORD_W-1];
                            shreg <= {shreg[tsr_pkg::WORD_W-2:0], 1'h0};
                            if (bit_cnt != tsr_pkg::CNT_SAT) begin
                                bit_cnt <= bit_cnt + 1'h1;
                            end
                        end
                    end
                end
                tsr_pkg::SPI_FLOAT: begin
                    serial_out_oe_n_o <= 1'h1;
                    if (cs_s) begin
                        state <= tsr_pkg::SPI_IDLE;
                    end
                end
                default: begin
                    state <= tsr_pkg::SPI_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_capture;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && state == tsr_pkg::SPI_IDLE && cs_fall) |=>
            (shreg[tsr_pkg::BIT_RSV_HI] && !shreg[tsr_pkg::BIT_RSV_LO]
             && shreg[tsr_pkg::BIT_PAR] == ~^shreg[tsr_pkg::BIT_PAR-1:0]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("captured word has bad reserved or parity bits");

    property p_err_pin;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && summary && stby_s) |=> !error_out_n_o;
    endproperty
    a_err_pin: assert property (p_err_pin)
        else $error("error pin not low with summary set");

    property p_float_idle;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && cs_s) |=> serial_out_oe_n_o;
    endproperty
    a_float_idle: assert property (p_float_idle)
        else $error("serial output driven with select high");

    property p_summary;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && |(cond & tsr_pkg::ERR_MASK)) |=> summary;
    endproperty
    a_summary: assert property (p_summary)
        else $error("error did not set the summary flag");

    property p_timeout;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && state == tsr_pkg::SPI_SHIFT && !cs_s
            && timer == TIMER_LAST)
            |=> serial_out_oe_n_o && spi_err_evt ##1 summary;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("read-out timeout not handled");

    property p_early_cs;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && state == tsr_pkg::SPI_IDLE && cs_fall && sclk_s)
            |=> frame_err;
    endproperty
    a_early_cs: assert property (p_early_cs)
        else $error("select fall with clock high not flagged");

    property p_mode;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && state == tsr_pkg::SPI_IDLE && cs_fall)
            |=> shreg[tsr_pkg::BIT_MODE] == $past(active_normal_mode_i);
    endproperty
    a_mode: assert property (p_mode)
        else $error("captured mode bit differs from actual mode");

    property p_no_summary;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && !summary && (cond & tsr_pkg::ERR_MASK) == '0
            && (wake_event_i || power_on_event_i || temp_warn_i))
            |=> !summary;
    endproperty
    a_no_summary: assert property (p_no_summary)
        else $error("non-error event set the summary flag");

    property p_rx;
        @(posedge clk_i) disable iff (reset_i)
        (ce_i && state == tsr_pkg::SPI_IDLE && cs_fall)
            |=> shreg[tsr_pkg::BIT_RX] == ~$past(rx_activity_flag_i);
    endproperty
    a_rx: assert property (p_rx)
        else $error("activity bit not live");

endmodule

// [tsr_host_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Host side of the status read-out port
// ------------------------------------------------------------
module tsr_host_model (
    // Clock
    input wire logic clk_i,
    // Serial port pins
    input wire logic serial_out_i,
    input wire logic serial_out_oe_n_i,
    output logic serial_select_n_o,
    output logic sclk_o
);
    // Select idles high and the serial clock stands still low
    initial begin
        serial_select_n_o = 1'h1;
        sclk_o = 1'h0;
    end

    // Changes land just after a system clock edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One frame of n serial clocks, each half period four system clocks
    task automatic read(input int n, input bit early, input int linger,
                        output logic [15:0] w, output logic [1:0] lead,
                        output logic tail);
        w = 16'h0000;
        if (early) begin
            sclk_o = 1'h1;
            wait_clk(4);
        end
        serial_select_n_o = 1'h0;
        wait_clk(5);
        lead = {serial_out_oe_n_i, serial_out_i};
        if (early) begin
            sclk_o = 1'h0;
            wait_clk(4);
        end
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'h1;
            wait_clk(4);
            sclk_o = 1'h0;
            wait_clk(4);
            // Sampled late in the low phase, after the bit has settled
            if (i < 16) begin
                w[15-i] = serial_out_oe_n_i ? 1'bz : serial_out_i;
            end
        end
        wait_clk(linger);
        tail = serial_out_oe_n_i;
        serial_select_n_o = 1'h1;
        // Select stays high well past the interframe gap
        wait_clk(10);
    endtask
endmodule

// [transceiver_status_register_test.sv]
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end

module transceiver_status_register_test;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic ce = 1'h1;
    logic sel_n, sclk, sout, sout_oe_n, err_n;
    logic stby_n = 1'h1, guard = 1'h1, mode = 1'h0, mchg = 1'h0, rx = 1'h0;
    logic [7:0] ev = 8'h00;
    logic [15:0] w, ex;
    logic [1:0] lead;
    logic tail;
    int fail_count = 0;
    int samples_checked = 0;
    // Status bit of each event input, and which of them are errors
    int ev_bit [8] = '{0, 4, 5, 6, 7, 8, 9, 11};
    logic [7:0] ev_err = 8'h7c;
    int bad_n [4] = '{15, 17, 16, 0};

    always #50 clk_i = ~clk_i;

    transceiver_status_register #(.READOUT_CYCLES(400)) DUT (
        .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
        .serial_select_n_i(sel_n), .sclk_i(sclk), .serial_out_o(sout),
        .serial_out_oe_n_o(sout_oe_n), .standby_control_n_i(stby_n),
        .guardian_enable_i(guard), .error_out_n_o(err_n),
        .active_normal_mode_i(mode), .mode_change_i(mchg),
        .wake_event_i(ev[0]), .power_on_event_i(ev[1]),
        .bus_error_i(ev[2]), .overtemp_i(ev[3]), .tx_timeout_i(ev[4]),
        .vcc_uv_i(ev[5]), .vio_uv_i(ev[6]), .temp_warn_i(ev[7]),
        .rx_activity_flag_i(rx)
    );

    tsr_host_model host (
        .clk_i(clk_i), .serial_out_i(sout), .serial_out_oe_n_i(sout_oe_n),
        .serial_select_n_o(sel_n), .sclk_o(sclk)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Expected word: flags high unless listed, parity worked out here
    function automatic logic [15:0] mkw(input logic [15:0] lows,
                                        input logic md);
        logic [15:0] x;
        x = 16'h3ffd & ~lows;
        x[1] = md;
        x[15] = ~^x[14:0];
        return x;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // A correct frame; the output must start driven low
    task automatic rd(input logic [15:0] e, input string nm);
        host.read(16, 1'b0, 0, w, lead, tail);
        `CHK({nm, " lead"}, 2'h0, lead)
        `CHK(nm, e, w)
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run is near 6000 cycles; this cuts a hang short
    initial begin
        #3000000;
        fail_count++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        step(16);
        reset_i = 1'h0;
        step(2);
        `CHK("idle float", 1'h1, sout_oe_n)
        rd(mkw(16'h0000, 1'h0), "reset word");
        `CHK("pin idle", 1'h1, err_n)
        // Each event once; the brief reference dip leaves only bit 12
        for (int k = 0; k < 8; k++) begin
            ev[k] = 1'h1;
            step(1);
            ev[k] = 1'h0;
            step(4);
            ex = (16'h0001 << ev_bit[k]) | (ev_err[k] ? 16'h1000 : 16'h0000);
            if (k == 6) begin
                ex = 16'h1000;
            end
            `CHK("pin", ~ev_err[k], err_n)
            rd(mkw(ex, 1'h0), "latched");
            rd(mkw(16'h0000, 1'h0), "cleared");
            `CHK("pin cleared", 1'h1, err_n)
        end
        // Standby pin low holds the error pin off
        stby_n = 1'h0;
        ev[2] = 1'h1;
        step(1);
        ev[2] = 1'h0;
        step(4);
        `CHK("pin masked", 1'h1, err_n)
        stby_n = 1'h1;
        step(6);
        `CHK("pin unmasked", 1'h0, err_n)
        // Mode change clears flags; reads leave the mode bit alone
        mode = 1'h1;
        mchg = 1'h1;
        step(1);
        mchg = 1'h0;
        step(2);
        rd(mkw(16'h0000, 1'h1), "mode change");
        rd(mkw(16'h0000, 1'h1), "mode kept");
        // Bus activity bit is live
        rx = 1'h1;
        step(2);
        rd(mkw(16'h0008, 1'h1), "rx busy");
        rx = 1'h0;
        step(4);
        rd(mkw(16'h0000, 1'h1), "rx idle");
        // Guardian off in normal mode; a read cannot clear it meanwhile
        guard = 1'h0;
        step(4);
        rd(mkw(16'h1004, 1'h1), "guard");
        guard = 1'h1;
        step(4);
        rd(mkw(16'h1004, 1'h1), "guard held");
        rd(mkw(16'h0000, 1'h1), "guard clear");
        // Short, long, early-clock and timed-out frames
        for (int k = 0; k < 4; k++) begin
            host.read(bad_n[k], k == 2, (k == 3) ? 450 : 0, w, lead, tail);
            if (k == 3) begin
                `CHK("timeout float", 1'h1, tail)
            end
            rd(mkw(16'h1400, 1'h1), "spi error");
            rd(mkw(16'h0000, 1'h1), "spi clear");
        end
        // Wake-up in normal mode is not flagged; a frozen clock ignores
        ev[0] = 1'h1;
        step(1);
        ev[0] = 1'h0;
        ce = 1'h0;
        ev[2] = 1'h1;
        step(2);
        ev[2] = 1'h0;
        ce = 1'h1;
        step(2);
        rd(mkw(16'h0000, 1'h1), "ignored events");
        // A reset in mid-run drops latched flags and frees the pin
        ev[5] = 1'h1;
        step(1);
        ev[5] = 1'h0;
        step(3);
        `CHK("pin before reset", 1'h0, err_n)
        reset_i = 1'h1;
        step(16);
        reset_i = 1'h0;
        step(2);
        `CHK("pin after reset", 1'h1, err_n)
        `CHK("float after reset", 1'h1, sout_oe_n)
        rd(mkw(16'h0000, 1'h1), "reset again");
        print_verdict();
    end
endmodule
